//--- rtl/bp_trace_trigger_map.vh
// offsets, field positions, reset values and codes of the breakpoint trace trigger control
`ifndef BP_TRACE_TRIGGER_MAP_VH
`define BP_TRACE_TRIGGER_MAP_VH
// ----------------------------------------------------------------
// register selects
// ----------------------------------------------------------------
`define SEL_INSTR_CTRL      2'h0
`define SEL_DATA_CTRL       2'h1
`define SEL_INSTR_CTRL_EXT  2'h2
`define SEL_DATA_CTRL_EXT   2'h3
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_MORE_BP         31
`define BIT_RSVD30          30
`define BIT_PCT             29
`define BIT_GLOBAL_EN       28
`define BIT_RSVD27          27
`define FIELD_W             3
`define PRIMARY_FIELDS      9
`define EXT_FIELDS          6
`define MAX_BP              15
// ----------------------------------------------------------------
// reset values and action codes
// ----------------------------------------------------------------
`define CTRL_RESET          32'h0000_0000
`define ACT_STOP_ALL        3'h0
`define ACT_START_CPU       3'h1
`define ACT_STOP_CPU        3'h2
`define ACT_START_ALL       3'h3
`define ACT_STOP_ALL_DUMP   3'h4
`define ACT_START_CPU_DUMP  3'h5
`define ACT_START_ALL_DUMP  3'h7
`define ACT_RESERVED        3'h6
`endif

//--- rtl/bp_trace_trigger_ctrl.v
// breakpoint-to-trace trigger control: action registers and trigger decode
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`include "bp_trace_trigger_map.vh"

module bp_trace_trigger_ctrl #(
  parameter NUM_INSTR_BP  = 15,
  parameter NUM_DATA_BP   = 15,
  parameter FULL_FIELDS   = 1
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        nrst,
  // register access port
  input  wire [1:0]  regSel,
  input  wire        regWrite,
  input  wire [31:0] regWdata,
  output reg  [31:0] regRdata,
  // breakpoint match logic
  input  wire [14:0] instrMatch,
  input  wire [14:0] dataMatch,
  // trace control logic
  output reg         actionValid,
  output reg         traceStart,
  output reg         coherenceScope,
  output reg         counterDump,
  output reg         perfCounterTrigger,
  output reg         traceOn,
  output reg         coherenceTraceOn
);

  // ----------------------------------------------------------------
  // configuration storage
  // ----------------------------------------------------------------
  localparam [2:0] FIELD_MASK = FULL_FIELDS ? 3'h7 : 3'h1;
  localparam INSTR_PRESENT = (NUM_INSTR_BP > 0);
  localparam DATA_PRESENT  = (NUM_DATA_BP > 0);

  reg  [44:0] instrFields;
  reg  [44:0] dataFields;
  reg         instrEnable;
  reg         dataEnable;
  reg         instrPct;
  reg         dataPct;

  // mask of bits that exist for a given number of breakpoints
  function [44:0] implMask;
    input integer count;
    integer k;
    begin
      implMask = 45'h0;
      for (k = 0; k < `MAX_BP; k = k + 1) begin
        if (k < count) begin
          implMask[k*`FIELD_W +: `FIELD_W] = FIELD_MASK;
        end
      end
    end
  endfunction

  // index of the lowest set bit; zero when no bit is set
  function [4:0] lowestSet;
    input [14:0] vec;
    integer k;
    begin
      lowestSet = 5'h0;
      for (k = `MAX_BP - 1; k >= 0; k = k - 1) begin
        if (vec[k]) begin
          lowestSet = k[4:0];
        end
      end
    end
  endfunction

  // one bit per breakpoint that exists
  function [14:0] presentBits;
    input integer count;
    integer k;
    begin
      presentBits = 15'h0000;
      for (k = 0; k < `MAX_BP; k = k + 1) begin
        if (k < count) begin
          presentBits[k] = 1'b1;
        end
      end
    end
  endfunction

  // the action field of one breakpoint out of a packed set
  function [2:0] fieldAt;
    input [44:0] fields;
    input [4:0]  idx;
    begin
      fieldAt = fields[idx*`FIELD_W +: `FIELD_W];
    end
  endfunction

  wire [44:0] instrMask = implMask(NUM_INSTR_BP);
  wire [44:0] dataMask  = implMask(NUM_DATA_BP);

  // write is taken when the select matches; the new value is visible next cycle
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      instrFields <= 45'h0;
      dataFields  <= 45'h0;
      instrEnable <= 1'b0;
      dataEnable  <= 1'b0;
      instrPct    <= 1'b0;
      dataPct     <= 1'b0;
    end else if (regWrite) begin
      case (regSel)
        `SEL_INSTR_CTRL: begin
          instrFields[26:0] <= regWdata[26:0] & instrMask[26:0];
          if (INSTR_PRESENT) begin
            instrEnable <= regWdata[`BIT_GLOBAL_EN];
            instrPct    <= regWdata[`BIT_PCT];
          end
        end
        `SEL_DATA_CTRL: begin
          dataFields[26:0] <= regWdata[26:0] & dataMask[26:0];
          if (DATA_PRESENT) begin
            dataEnable <= regWdata[`BIT_GLOBAL_EN];
            dataPct    <= regWdata[`BIT_PCT];
          end
        end
        `SEL_INSTR_CTRL_EXT: begin
          instrFields[44:27] <= regWdata[17:0] & instrMask[44:27];
        end
        `SEL_DATA_CTRL_EXT: begin
          dataFields[44:27] <= regWdata[17:0] & dataMask[44:27];
        end
        default: begin
          instrFields <= instrFields;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read-back
  // ----------------------------------------------------------------
  wire moreInstr = (NUM_INSTR_BP > `PRIMARY_FIELDS);
  wire moreData  = (NUM_DATA_BP > `PRIMARY_FIELDS);
  reg  [31:0] next_regRdata;

  always @* begin
    next_regRdata = `CTRL_RESET;
    case (regSel)
      `SEL_INSTR_CTRL: begin
        next_regRdata[26:0]            = instrFields[26:0];
        next_regRdata[`BIT_GLOBAL_EN]  = instrEnable;
        next_regRdata[`BIT_PCT]        = instrPct;
        next_regRdata[`BIT_MORE_BP]    = moreInstr;
      end
      `SEL_DATA_CTRL: begin
        next_regRdata[26:0]            = dataFields[26:0];
        next_regRdata[`BIT_GLOBAL_EN]  = dataEnable;
        next_regRdata[`BIT_PCT]        = dataPct;
        next_regRdata[`BIT_MORE_BP]    = moreData;
      end
      `SEL_INSTR_CTRL_EXT: begin
        next_regRdata[17:0] = instrFields[44:27];
      end
      `SEL_DATA_CTRL_EXT: begin
        next_regRdata[17:0] = dataFields[44:27];
      end
      default: begin
        next_regRdata = `CTRL_RESET;
      end
    endcase
    // bits 30 and 27 are never assigned above, so they stay zero
    next_regRdata[`BIT_RSVD30] = 1'b0;
    next_regRdata[`BIT_RSVD27] = 1'b0;
  end

  // ----------------------------------------------------------------
  // trigger qualification
  // ----------------------------------------------------------------
  // a match on a breakpoint that does not exist is dropped: its field
  // reads zero and would otherwise decode as a stop of everything
  wire [14:0] instrExists = presentBits(NUM_INSTR_BP);
  wire [14:0] dataExists  = presentBits(NUM_DATA_BP);
  wire [14:0] instrLive   = instrEnable ? (instrMatch & instrExists) : 15'h0000;
  wire [14:0] dataLive    = dataEnable ? (dataMatch & dataExists) : 15'h0000;
  wire [4:0]  instrIdx    = lowestSet(instrLive);
  wire [4:0]  dataIdx     = lowestSet(dataLive);
  wire        instrFire   = |instrLive;
  wire        dataFire    = |dataLive;
  // instruction side wins outright; data triggers of that cycle are lost
  wire        useInstr    = instrFire;
  wire        anyFire     = instrFire | dataFire;
  wire [2:0]  code        = useInstr ? fieldAt(instrFields, instrIdx)
                                     : fieldAt(dataFields, dataIdx);
  wire        pctSel      = useInstr ? instrPct : dataPct;

  // ----------------------------------------------------------------
  // action decode
  // ----------------------------------------------------------------
  reg         decKnown;
  reg         decStart;
  reg         decAll;
  reg         decDump;

  // upper code bits are zero when only the lsb is kept, so the same
  // decode serves both field widths
  always @* begin
    decKnown = 1'b1;
    decStart = 1'b0;
    decAll   = 1'b0;
    decDump  = 1'b0;
    case (code)
      `ACT_STOP_ALL: begin
        decAll = 1'b1;
      end
      `ACT_START_CPU: begin
        decStart = 1'b1;
      end
      `ACT_STOP_CPU: begin
        decStart = 1'b0;
      end
      `ACT_START_ALL: begin
        decStart = 1'b1;
        decAll   = 1'b1;
      end
      `ACT_STOP_ALL_DUMP: begin
        decAll  = 1'b1;
        decDump = 1'b1;
      end
      `ACT_START_CPU_DUMP: begin
        decStart = 1'b1;
        decDump  = 1'b1;
      end
      `ACT_START_ALL_DUMP: begin
        decStart = 1'b1;
        decAll   = 1'b1;
        decDump  = 1'b1;
      end
      default: begin
        // the reserved code raises no trace action, though perfCounterTrigger still follows the PCT bit; a safe default for a software slip
        decKnown = 1'b0;
      end
    endcase
  end

  wire        codeValid   = anyFire & decKnown;

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      regRdata           <= `CTRL_RESET;
      actionValid        <= 1'b0;
      traceStart         <= 1'b0;
      coherenceScope     <= 1'b0;
      counterDump        <= 1'b0;
      perfCounterTrigger <= 1'b0;
    end else begin
      regRdata           <= next_regRdata;
      actionValid        <= codeValid;
      traceStart         <= codeValid & decStart;
      coherenceScope     <= codeValid & decAll;
      counterDump        <= codeValid & decDump;
      perfCounterTrigger <= anyFire & pctSel;
    end
  end

  // ----------------------------------------------------------------
  // trace state
  // ----------------------------------------------------------------
  // writing the level it already holds leaves trace as it was, so a
  // repeated start or stop needs no extra state
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      traceOn          <= 1'b0;
      coherenceTraceOn <= 1'b0;
    end else begin
      if (codeValid) begin
        traceOn <= decStart;
      end
      if (codeValid & decAll) begin
        coherenceTraceOn <= decStart;
      end
    end
  end

endmodule // bp_trace_trigger_ctrl

//--- bench/bp_trace_trigger_chk.sv
// assertions on the breakpoint trace trigger ports
module bp_trace_trigger_chk (
  // clock and reset
  input wire        clk_sys,
  input wire        nrst,
  // register port
  input wire [1:0]  regSel,
  input wire [31:0] regRdata,
  // trigger path
  input wire [14:0] instrMatch,
  input wire [14:0] dataMatch,
  input wire        actionValid,
  input wire        traceStart,
  input wire        coherenceScope,
  input wire        counterDump,
  input wire        traceOn,
  input wire        coherenceTraceOn
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  chk_idle_quiet:
    assert property (instrMatch == 0 && dataMatch == 0 |=> !actionValid) else $error("stray action");
  chk_start_on:
    assert property (actionValid && traceStart |-> traceOn) else $error("start left trace off");
  chk_stop_off:
    assert property (actionValid && !traceStart |-> !traceOn) else $error("stop left trace on");
  chk_scope_start:
    assert property (actionValid && traceStart && coherenceScope |-> coherenceTraceOn)
      else $error("coherence not started");
  chk_cpu_only:
    assert property (actionValid && !coherenceScope |-> $stable(coherenceTraceOn))
      else $error("coherence state moved");
  chk_hold_state:
    assert property (!actionValid |-> $stable(traceOn)) else $error("trace state moved idle");
  chk_dump_action:
    assert property (counterDump |-> actionValid) else $error("dump without action");
  chk_rsvd_zero:
    assert property (!regRdata[30] && !regRdata[27]) else $error("reserved bit set");
  chk_ext_upper:
    assert property ($past(regSel[1]) |-> regRdata[31:18] == 14'h0000) else $error("ext upper set");
endmodule // bp_trace_trigger_chk

//--- bench/bp_match_source.sv
// breakpoint match source: one-cycle match pulses on request
module bp_match_source (
  // clock
  input  wire        clk_sys,
  // request
  input  wire        go,
  input  wire [14:0] iReq,
  input  wire [14:0] dReq,
  // match pulses
  output reg  [14:0] instrMatch = 15'h0000,
  output reg  [14:0] dataMatch = 15'h0000
);
  timeunit 1ns;
  timeprecision 1ns;
  // pulses follow go by one cycle; go is raised for one cycle per request
  always @(posedge clk_sys) begin
    instrMatch <= go ? iReq : 15'h0000;
    dataMatch <= go ? dReq : 15'h0000;
  end
endmodule // bp_match_source

//--- bench/testbench.sv
// self-checking bench for the breakpoint trace trigger control
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, nrst = 0, regWrite = 0, go = 0;
  logic [1:0] regSel = 2'h0;
  logic [31:0] regWdata = 32'h0000_0000;
  logic [14:0] iReq = 15'h0000, dReq = 15'h0000;
  wire [31:0] regRdata, regRdataSmall;
  wire [14:0] instrMatch, dataMatch;
  wire actionValid, traceStart, coherenceScope, counterDump, perfCounterTrigger;
  wire traceOn, coherenceTraceOn;
  int miscompares = 0, compares = 0;
  always #5 clk_sys = ~clk_sys;
  bp_trace_trigger_ctrl bp_trace_trigger_ctrl_inst (.clk_sys, .nrst, .regSel, .regWrite,
    .regWdata, .regRdata, .instrMatch, .dataMatch, .actionValid, .traceStart, .coherenceScope,
    .counterDump, .perfCounterTrigger, .traceOn, .coherenceTraceOn);
  bp_match_source bp_match_source_inst (.clk_sys, .go, .iReq, .dReq, .instrMatch, .dataMatch);
  // a small build: no instruction breakpoints, four data ones, lsb-only fields
  bp_trace_trigger_ctrl #(.NUM_INSTR_BP(0), .NUM_DATA_BP(4), .FULL_FIELDS(0))
    bp_trace_trigger_ctrl_small_inst (.clk_sys(clk_sys), .nrst(nrst), .regSel(regSel),
    .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdataSmall),
    .instrMatch(instrMatch), .dataMatch(dataMatch), .actionValid(), .traceStart(),
    .coherenceScope(), .counterDump(), .perfCounterTrigger(), .traceOn(),
    .coherenceTraceOn());
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %0t %h %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [1:0] s, input logic [31:0] d);
    @(posedge clk_sys) #1;
    regSel = s;
    regWdata = d;
    regWrite = 1;
    @(posedge clk_sys) #1;
    regWrite = 0;
  endtask
  task automatic rd(input logic [1:0] s, input logic [31:0] e, input logic [31:0] e2);
    @(posedge clk_sys) #1;
    regSel = s;
    repeat (2) @(posedge clk_sys);
    #1 cmp(regRdata, e);
    cmp(regRdataSmall, e2);
  endtask
  // action outputs stand one cycle, so they are sampled right after the deciding edge
  task automatic fire(input logic [14:0] i, input logic [14:0] d, input logic [6:0] e);
    @(posedge clk_sys) #1;
    iReq = i;
    dReq = d;
    go = 1;
    @(posedge clk_sys) #1;
    go = 0;
    @(posedge clk_sys) #1;
    cmp({actionValid, traceStart, coherenceScope, counterDump, perfCounterTrigger, traceOn,
      coherenceTraceOn}, e);
  endtask
  task automatic t_regs;
    rd(2'h0, 32'h8000_0000, 32'h0000_0000);
    rd(2'h3, 32'h0000_0000, 32'h0000_0000);
    wr(2'h0, 32'hFFFF_FFFF);
    rd(2'h0, 32'hB7FF_FFFF, 32'h0000_0000);
    wr(2'h1, 32'hFFFF_FFFF);
    rd(2'h1, 32'hB7FF_FFFF, 32'h3000_0249);
    wr(2'h2, 32'hFFFF_FFFF);
    rd(2'h2, 32'h0003_FFFF, 32'h0000_0000);
    wr(2'h3, 32'hFFFF_FFFF);
    rd(2'h3, 32'h0003_FFFF, 32'h0000_0000);
    wr(2'h2, 32'h0000_0000);
    wr(2'h3, 32'h0000_0000);
  endtask
  task automatic t_codes;
    for (int c = 0; c < 8; c++) begin
      logic [6:0] e;
      e = {1'b1, c[0], c[1] == c[0], c[2], 1'b0, c[0], c[1] & c[0]};
      if (c != 6) begin
        wr(2'h0, 32'h1000_0000 | c);
        fire(15'h0001, 15'h0000, e);
      end
    end
  endtask
  task automatic t_gate;
    wr(2'h0, 32'h0000_0001);
    fire(15'h0001, 15'h0000, 7'h03);
    wr(2'h0, 32'h1000_0002);
    wr(2'h1, 32'h1000_0001);
    fire(15'h0000, 15'h0001, 7'h63);
    fire(15'h0001, 15'h0001, 7'h41);
  endtask
  task automatic t_prio;
    wr(2'h0, 32'h3000_000A);
    fire(15'h0003, 15'h0000, 7'h45);
    fire(15'h0002, 15'h0000, 7'h67);
    fire(15'h0002, 15'h0000, 7'h67);
    wr(2'h0, 32'h2000_000A);
    fire(15'h0002, 15'h0000, 7'h03);
    wr(2'h1, 32'h3000_0002);
    fire(15'h0000, 15'h0001, 7'h45);
    wr(2'h1, 32'h2000_0002);
    fire(15'h0000, 15'h0001, 7'h01);
  endtask
  task automatic t_reset;
    @(posedge clk_sys) #1;
    nrst = 0;
    repeat (2) @(posedge clk_sys);
    #1 nrst = 1;
    cmp({actionValid, traceOn, coherenceTraceOn}, 32'h0000_0000);
    rd(2'h0, 32'h8000_0000, 32'h0000_0000);
    rd(2'h1, 32'h8000_0000, 32'h0000_0000);
    fire(15'h0001, 15'h0001, 7'h00);
  endtask
  task automatic results;
    if (miscompares == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    #1 nrst = 1;
    t_regs;
    t_codes;
    t_gate;
    t_prio;
    t_reset;
    results;
  end
  initial begin
    #20000;
    miscompares++;
    results;
  end
endmodule // testbench
bind bp_trace_trigger_ctrl bp_trace_trigger_chk bp_trace_trigger_chk_inst (.clk_sys, .nrst,
  .regSel, .regRdata, .instrMatch, .dataMatch, .actionValid, .traceStart, .coherenceScope,
  .counterDump, .traceOn, .coherenceTraceOn);
